// >>> verilog/signal_source_config_registers.sv
// Design decision made here: the strobed register port.
module signal_source_config_registers
  import sigsrc_cfg_pkg::*;
#(
  parameter int CNT_BITS = CNT_W
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_nrst,
  input  wire logic [ADDR_W-1:0]         i_addr,
  input  wire logic [DATA_W-1:0]         i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [DATA_W-1:0]         o_rdata,
  input  wire logic                      i_load_stop,
  input  wire logic [CNT_BITS-1:0]       i_load_count,
  input  wire logic                      i_count_ovr,
  input  wire logic [CNT_BITS-1:0]       i_count_ovr_val,
  input  wire logic                      i_ext_ref_pin,
  input  wire logic                      i_rev_f_or_later,
  input  wire logic                      i_xfer_done,
  output logic                           o_store_req,
  output logic                           o_recall_req,
  output logic      [CNT_BITS-1:0]       o_xfer_count,
  output logic                           o_trigger,
  output logic      [FREQ_W-1:0]         o_tune_word,
  output logic                           o_tune_load,
  output logic      [LVL_MAG_W-1:0]      o_level_mag,
  output logic                           o_level_neg,
  output logic                           o_relevel,
  output logic                           o_output_on,
  output logic      [PHASE_W-1:0]        o_phase,
  output logic                           o_standby,
  output logic                           o_ext_lock,
  output logic                           o_refout_100m,
  output logic                           o_backplane_clk_en,
  output logic                           o_direct_clk,
  output logic                           o_ext_expect_100m,
  output logic      [TRIM_W-1:0]         o_trim_dac
);
  //////////////////////////////////////////////////////////////////////////
  // command framing: a write whose data byte is a register address opens it,
  // then data bytes follow msb first; i_addr is not decoded for writes
  typedef enum logic [1:0] {
    IDLE,
    COLLECT
  } frame_t;

  frame_t      st_q, st_d;
  logic [7:0]  reg_q;
  logic [1:0]  busy_q;

  function automatic logic [2:0] reg_len(input logic [7:0] a);
    unique case (a)
      A_FREQ, A_LEVEL, A_PHASE: reg_len = LEN_7;
      A_TRIM:                   reg_len = LEN_3;
      default:                  reg_len = LEN_1;
    endcase
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a >= A_XFER) && (a <= A_TRIM);
  endfunction

  logic [55:0] word;
  logic        word_done;

  // first write names the register, following writes carry its bytes;
  // the commit cycle already takes a new address, so writes need no gap
  wire         frame_free = st_q == IDLE || word_done;
  wire         open_cmd  = i_wr && frame_free && known(i_wdata);
  wire         data_wr   = i_wr && !frame_free;
  wire [7:0]   open_reg  = i_wdata;
  wire         unused_a  = ^i_addr;

  byte_assembler #(.W(FREQ_W)) u_asm (
    .i_clk_sys  (i_clk_sys),
    .i_nrst     (i_nrst),
    .i_start    (open_cmd),
    .i_byte_vld (data_wr),
    .i_byte     (i_wdata),
    .i_len      (reg_len(open_reg)),
    .o_word     (word),
    .o_done     (word_done)
  );

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      IDLE:    if (open_cmd) st_d = COLLECT;
      COLLECT: if (word_done && !open_cmd) st_d = IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // decoded commits, each only after the whole word arrived
  wire c_xfer  = word_done && reg_q == A_XFER;
  wire c_trig  = word_done && reg_q == A_TRIG;
  wire c_freq  = word_done && reg_q == A_FREQ;
  wire c_level = word_done && reg_q == A_LEVEL;
  wire c_ena   = word_done && reg_q == A_ENA;
  wire c_phase = word_done && reg_q == A_PHASE;
  wire c_lvbyp = word_done && reg_q == A_LVBYP;
  wire c_stby  = word_done && reg_q == A_STBY;
  wire c_ref   = word_done && reg_q == A_REF;
  wire c_trim  = word_done && reg_q == A_TRIM;

  // a nonzero trigger byte is ignored; host keeps unused bits zero
  wire trig_ok = c_trig && word[7:0] == 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // external reference detect: three flops, change when 2nd and 3rd agree
  logic [2:0] ref_sync_q;
  logic       ref_seen_q;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ref_sync_q <= 3'h0;
      ref_seen_q <= 1'b0;
    end else begin
      ref_sync_q <= {ref_sync_q[1:0], i_ext_ref_pin};
      if (ref_sync_q[1] == ref_sync_q[2])
        ref_seen_q <= ref_sync_q[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // point count: load stop value unless host override
  logic [CNT_BITS-1:0] count_q;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst)
      count_q <= '0;
    else if (i_count_ovr)
      count_q <= i_count_ovr_val;
    else if (i_load_stop)
      count_q <= i_load_count;
  end

  //////////////////////////////////////////////////////////////////////////
  // settings
  logic       lvbyp_q;
  logic [4:0] ref_q;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q               <= IDLE;
      reg_q              <= 8'h00;
      o_tune_word        <= FREQ_RST;
      o_level_mag        <= LEVEL_RST[LVL_MAG_W-1:0];
      o_level_neg        <= 1'b0;
      o_output_on        <= 1'b0;
      o_phase            <= '0;
      lvbyp_q            <= 1'b0;
      o_standby          <= 1'b0;
      ref_q              <= REF_RST;
      o_trim_dac         <= TRIM_RST;
    end else begin
      st_q <= st_d;
      if (open_cmd)
        reg_q <= open_reg;
      if (c_freq)
        o_tune_word <= word;
      if (c_level) begin
        o_level_mag <= word[LVL_MAG_W-1:0];
        o_level_neg <= word[B_SIGN];
      end
      if (c_ena)
        o_output_on <= word[0];
      if (c_phase)
        o_phase <= word[PHASE_W-1:0];
      if (c_lvbyp)
        lvbyp_q <= word[0];
      if (c_stby)
        o_standby <= word[0];
      if (c_ref)
        ref_q <= word[4:0];
      if (c_trim)
        o_trim_dac <= word[TRIM_W-1:0];
    end
  end

  // revision-dependent bits have no effect on older boards
  wire rev_ok = i_rev_f_or_later;
  assign o_ext_lock         = ref_q[B_LOCK] && ref_seen_q;
  assign o_refout_100m      = ref_q[B_REFOUT];
  assign o_backplane_clk_en = ref_q[B_BPCLK];
  assign o_direct_clk       = ref_q[B_DIRECT] && rev_ok;
  assign o_ext_expect_100m  = ref_q[B_EXTFREQ] && rev_ok;

  //////////////////////////////////////////////////////////////////////////
  // pulses and memory transfer
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_trigger    <= 1'b0;
      o_tune_load  <= 1'b0;
      o_relevel    <= 1'b0;
      o_store_req  <= 1'b0;
      o_recall_req <= 1'b0;
      o_xfer_count <= '0;
      busy_q       <= 2'h0;
    end else begin
      o_trigger   <= trig_ok;
      o_tune_load <= c_freq;
      // relevel on tune change unless bypassed, always on level write
      o_relevel   <= c_level || (c_freq && !lvbyp_q);
      o_store_req  <= 1'b0;
      o_recall_req <= 1'b0;
      if (c_xfer && busy_q == 2'h0) begin
        if (word[B_DIR]) begin
          o_recall_req <= 1'b1;
          busy_q       <= 2'h2;
        end else begin
          o_store_req  <= 1'b1;
          o_xfer_count <= count_q;
          busy_q       <= 2'h1;
        end
      end else if (i_xfer_done)
        busy_q <= 2'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status read: a transfer still running refuses a new one
  wire [7:0] stat = {4'h0, ref_seen_q, busy_q, st_q == COLLECT};
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst)
      o_rdata <= 8'h00;
    else if (i_rd && i_addr == A_STAT)
      o_rdata <= stat;
    else
      o_rdata <= {7'h00, unused_a & 1'b0};
  end
endmodule // signal_source_config_registers

// >>> verilog/sigsrc_cfg_pkg.sv
package sigsrc_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;

  localparam logic [7:0] A_XFER  = 8'h0E;
  localparam logic [7:0] A_TRIG  = 8'h0F;
  localparam logic [7:0] A_FREQ  = 8'h10;
  localparam logic [7:0] A_LEVEL = 8'h11;
  localparam logic [7:0] A_ENA   = 8'h12;
  localparam logic [7:0] A_PHASE = 8'h13;
  localparam logic [7:0] A_LVBYP = 8'h14;
  localparam logic [7:0] A_STBY  = 8'h16;
  localparam logic [7:0] A_REF   = 8'h17;
  localparam logic [7:0] A_TRIM  = 8'h18;
  // status register of our own, shows block state
  localparam logic [7:0] A_STAT  = 8'h30;

  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_7 = 3'h7;

  localparam int B_DIR     = 0;
  localparam int B_LOCK    = 0;
  localparam int B_REFOUT  = 1;
  localparam int B_BPCLK   = 2;
  localparam int B_DIRECT  = 3;
  localparam int B_EXTFREQ = 4;
  localparam int B_SIGN    = 15;
  localparam int LVL_MAG_W = 15;
  localparam int PHASE_W   = 31;
  localparam int TRIM_W    = 14;
  localparam int FREQ_W    = 56;

  localparam logic [55:0] FREQ_RST  = 56'h0;
  localparam logic [15:0] LEVEL_RST = 16'h0;
  localparam logic [4:0]  REF_RST   = 5'h0;
  localparam logic [13:0] TRIM_RST  = 14'h2000;
endpackage

// >>> verilog/byte_assembler.sv
// gathers msb-first bytes into a word, applied only when complete
module byte_assembler
  import sigsrc_cfg_pkg::*;
#(
  parameter int W = 56
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_start,
  input  wire logic         i_byte_vld,
  input  wire logic [7:0]   i_byte,
  input  wire logic [2:0]   i_len,
  output logic [W-1:0]      o_word,
  output logic              o_done
);
  logic [W-1:0] shift_q;
  logic [2:0]   left_q;
  wire          last_byte = i_byte_vld && (left_q == 3'h1);
  wire [W-1:0]  shifted = {shift_q[W-9:0], i_byte};

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_q <= '0;
      left_q  <= 3'h0;
      o_word  <= '0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        shift_q <= '0;
        left_q  <= i_len;
      end else if (i_byte_vld && left_q != 3'h0) begin
        shift_q <= shifted;
        left_q  <= left_q - 3'h1;
        if (last_byte) begin
          o_word <= shifted;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule // byte_assembler

// >>> dv/sigsrc_cfg_asserts.sv
module sigsrc_cfg_checker
  import sigsrc_cfg_pkg::*;
(
  input wire logic               i_clk_sys,
  input wire logic               i_nrst,
  input wire logic               i_wr,
  input wire logic [DATA_W-1:0]  i_wdata,
  input wire logic               i_ext_ref_pin,
  input wire logic               i_rev_f_or_later,
  input wire logic               o_trigger,
  input wire logic               o_store_req,
  input wire logic               o_recall_req,
  input wire logic               o_tune_load,
  input wire logic               o_relevel,
  input wire logic [FREQ_W-1:0]  o_tune_word,
  input wire logic [PHASE_W-1:0] o_phase,
  input wire logic               o_ext_lock,
  input wire logic               o_direct_clk,
  input wire logic               o_ext_expect_100m
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  //////////////////////////////////////////////////////////////////////
  // pulses trail the last data byte by two edges
  chk_trig_zero: assert property (o_trigger |->
    $past(i_wr, 2) && $past(i_wdata, 2) == 8'h00) else $error("bad trigger");
  chk_store_dir: assert property (o_store_req |->
    $past(i_wr, 2) && !$past(i_wdata[B_DIR], 2)) else $error("bad store");
  chk_recall_dir: assert property (o_recall_req |->
    $past(i_wr, 2) && $past(i_wdata[B_DIR], 2)) else $error("bad recall");
  chk_tune_pulse: assert property (o_tune_load |->
    $past(i_wr, 2) ##1 !o_tune_load) else $error("bad tune pulse");
  chk_relevel_cause: assert property (o_relevel |->
    $past(i_wr, 2)) else $error("relevel without write");
  // a word changes one edge after the edge that takes its last byte
  chk_tune_whole: assert property (!$stable(o_tune_word) |->
    $past(i_wr, 2)) else $error("tune word moved alone");
  chk_phase_whole: assert property ($changed(o_phase) |->
    $past(i_wr, 2)) else $error("phase moved alone");
  // sync chain needs a few edges to forget the pin
  chk_lock_gate: assert property ((!i_ext_ref_pin) [*6] |->
    !o_ext_lock) else $error("lock without reference");
  chk_direct_rev: assert property (o_direct_clk |->
    i_rev_f_or_later) else $error("direct clock on old revision");
  chk_extfreq_rev: assert property (o_ext_expect_100m |->
    i_rev_f_or_later) else $error("ref select on old revision");
  cover property (o_trigger);
  cover property (o_store_req);
  cover property (o_ext_lock);
endmodule // sigsrc_cfg_checker

bind signal_source_config_registers sigsrc_cfg_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_wr(i_wr), .i_wdata(i_wdata),
  .i_ext_ref_pin(i_ext_ref_pin), .i_rev_f_or_later(i_rev_f_or_later),
  .o_trigger(o_trigger), .o_store_req(o_store_req),
  .o_recall_req(o_recall_req), .o_tune_load(o_tune_load),
  .o_relevel(o_relevel), .o_tune_word(o_tune_word), .o_phase(o_phase),
  .o_ext_lock(o_ext_lock), .o_direct_clk(o_direct_clk),
  .o_ext_expect_100m(o_ext_expect_100m));

// >>> dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sigsrc_cfg_pkg::*;
  logic i_clk_sys = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_load_stop = 0;
  logic i_count_ovr = 0, i_ext_ref_pin = 0, i_rev_f_or_later = 0;
  logic i_xfer_done = 0, o_store_req, o_recall_req, o_trigger, o_tune_load;
  logic o_level_neg, o_relevel, o_output_on, o_standby, o_ext_lock;
  logic o_refout_100m, o_backplane_clk_en, o_direct_clk, o_ext_expect_100m;
  logic [7:0]  i_addr = 0, i_wdata = 0, o_rdata;
  logic [15:0] i_load_count = 0, i_count_ovr_val = 0, o_xfer_count;
  logic [55:0] o_tune_word;
  logic [14:0] o_level_mag;
  logic [30:0] o_phase;
  logic [13:0] o_trim_dac;
  int          num_errors = 0, n_compared = 0, cycles = 0;
  signal_source_config_registers #(.CNT_BITS(16)) u_dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_load_stop(i_load_stop), .i_load_count(i_load_count),
    .i_count_ovr(i_count_ovr), .i_count_ovr_val(i_count_ovr_val),
    .i_ext_ref_pin(i_ext_ref_pin), .i_rev_f_or_later(i_rev_f_or_later),
    .i_xfer_done(i_xfer_done), .o_store_req(o_store_req),
    .o_recall_req(o_recall_req), .o_xfer_count(o_xfer_count),
    .o_trigger(o_trigger), .o_tune_word(o_tune_word),
    .o_tune_load(o_tune_load), .o_level_mag(o_level_mag),
    .o_level_neg(o_level_neg), .o_relevel(o_relevel),
    .o_output_on(o_output_on), .o_phase(o_phase), .o_standby(o_standby),
    .o_ext_lock(o_ext_lock), .o_refout_100m(o_refout_100m),
    .o_backplane_clk_en(o_backplane_clk_en), .o_direct_clk(o_direct_clk),
    .o_ext_expect_100m(o_ext_expect_100m), .o_trim_dac(o_trim_dac));
  //////////////////////////////////////////////////////////////////////
  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_compared++;
    if (e !== g) begin
      num_errors++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic tick;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic put(logic [7:0] b);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_wdata <= b;
  endtask
  // address byte, then n bytes msb first; unused upper bits stay zero;
  // returns while the new setting and its one-cycle pulse both stand
  task automatic wreg(logic [7:0] a, logic [55:0] v, int n);
    put(a);
    for (int i = n - 1; i >= 0; i--) put(v[8*i +: 8]);
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rreg(logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  // newer-revision bits are masked on old hardware
  function automatic logic [3:0] ref_exp(logic [4:0] r, logic rev);
    return {r[4] & rev, r[3] & rev, r[2], r[1]};
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] v;
    logic [7:0]  d;
    v = $urandom(286);
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    #1;
    chk("trim_rst", 14'h2000, o_trim_dac);
    chk("tune_rst", 0, o_tune_word);
    for (int k = 0; k < 16; k++) begin
      v = {$urandom(), $urandom()};
      wreg(A_FREQ, v[55:0], 7);
      chk("tune", v[55:0], o_tune_word);
      chk("tune_load", 1, o_tune_load);
      wreg(A_LEVEL, {40'h0, v[15:0]}, 7);
      chk("level", v[15:0], {o_level_neg, o_level_mag});
      wreg(A_PHASE, {25'h0, v[30:0]}, 7);
      chk("phase", v[30:0], o_phase);
      wreg(A_TRIM, {42'h0, v[13:0]}, 3);
      chk("trim", v[13:0], o_trim_dac);
      i_rev_f_or_later <= v[40];
      wreg(A_REF, {51'h0, v[36:32]}, 1);
      chk("ref", ref_exp(v[36:32], v[40]), {o_ext_expect_100m, o_direct_clk,
          o_backplane_clk_en, o_refout_100m});
      chk("no_lock", 0, o_ext_lock);
      wreg(A_ENA, {55'h0, v[41]}, 1);
      chk("on", v[41], o_output_on);
      wreg(A_STBY, {55'h0, v[42]}, 1);
      chk("standby", v[42], o_standby);
    end
    for (int b = 0; b < 2; b++) begin
      wreg(A_LVBYP, 56'(b), 1);
      wreg(A_FREQ, 56'h1234, 7);
      chk("relevel_tune", !b, o_relevel);
    end
    wreg(A_LEVEL, 56'h401, 7);
    chk("relevel_lvl", 1, o_relevel);
    wreg(A_TRIG, 56'h0, 1);
    chk("trig", 1, o_trigger);
    wreg(A_TRIG, 56'h5A, 1);
    chk("trig_nz", 0, o_trigger);
    @(posedge i_clk_sys);
    i_load_stop <= 1'b1;
    i_load_count <= 16'h07FF;
    @(posedge i_clk_sys);
    i_load_stop <= 1'b0;
    wreg(A_XFER, 56'h0, 1);
    chk("store", 1, o_store_req);
    chk("count", 16'h07FF, o_xfer_count);
    wreg(A_XFER, 56'h1, 1);
    chk("busy_recall", 0, o_recall_req);
    @(posedge i_clk_sys);
    i_xfer_done <= 1'b1;
    i_count_ovr <= 1'b1;
    i_count_ovr_val <= 16'(v[15:0]);
    @(posedge i_clk_sys);
    i_xfer_done <= 1'b0;
    i_count_ovr <= 1'b0;
    wreg(A_XFER, 56'h1, 1);
    chk("recall", 1, o_recall_req);
    @(posedge i_clk_sys);
    i_xfer_done <= 1'b1;
    @(posedge i_clk_sys);
    i_xfer_done <= 1'b0;
    wreg(A_XFER, 56'h0, 1);
    chk("count_ovr", v[15:0], o_xfer_count);
    // partial word must not reach the output
    wreg(A_PHASE, 56'h55, 7);
    put(A_PHASE);
    repeat (4) put(8'h00);
    repeat (2) put(8'h12);
    #1;
    chk("partial", 31'h55, o_phase);
    put(8'h34);
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    tick();
    chk("whole", 31'h121234, o_phase);
    wreg(A_ENA, 56'h0, 1);
    put(8'h40);
    put(8'h01);
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    tick();
    chk("unmapped", 0, o_output_on);
    // next address right after a last byte is taken, no idle needed
    wreg(A_STBY, 56'h0, 1);
    put(A_ENA);
    put(8'h01);
    put(A_STBY);
    put(8'h01);
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    tick();
    chk("b2b_on", 1, o_output_on);
    chk("b2b_stby", 1, o_standby);
    wreg(A_REF, 56'h1, 1);
    chk("lock_off", 0, o_ext_lock);
    i_ext_ref_pin <= 1'b1;
    repeat (6) tick();
    chk("lock_on", 1, o_ext_lock);
    rreg(A_STAT, d);
    chk("ref_seen", 1, d[3]);
    rreg(8'h05, d);
    chk("rd_unmapped", 0, d);
    complete_run();
  end
endmodule // testbench
